// ### hdl/serial_tx.sv
// Purpose: asynchronous serial transmitter with Avalon-MM registers
// Assumes: 25 MHz clock_in, synchronous active-high reset
// Notes: one clock is one instruction cycle
// Summary of operation
// R1 - line idles high, NRZ levels
// R2 - start low, 8/9 data, stop high
// R3 - data bits least significant first
// R4 - each bit one baud period, 8-bit divider
// R5 - no parity generated; ninth bit carries it
// R6 - runs only with enable, async, port on
// R7 - port enable makes transmit pin output
// R8 - port enable forces receive pin input
// R9 - setting transmit enable sets empty flag
// R10 - empty shifter loads written character immediately
// R11 - queued character loads after stop bit
// R12 - empty flag clear only when busy and queued; the code also clears it whenever run is low
// R13 - empty flag updates second cycle after write
// R14 - empty flag read only
// R15 - irq enable gates request, not flag
// R16 - software clears irq enable after last character
// R17 - shifter empty bit, no interrupt
// R18 - nine-bit select shifts nine data bits
// R19 - ninth bit written first, moved together
// R20 - ninth bit one marks an address
// R21 - all enables plus flag request interrupt
// R22 - software follows documented setup order
// R23 - disabled transmitter holds idle at mark
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module serial_tx (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic receive_data_pin_in,
	output logic transmit_clock_pin_out,
	output logic transmit_clock_pin_oe_out,
	output logic receive_data_pin_oe_out,
	output logic irq_out
);
	import serial_tx_pkg::*;

	typedef struct packed {
		logic [7:0] tx_ctrl;
		logic [7:0] rx_ctrl;
		logic [7:0] divider;
		logic [7:0] mask;
		logic [7:0] irq_ctrl;
		logic [7:0] holding;
		logic holding_ninth;
		logic holding_full;
		logic [1:0] lag;
		logic flag;
		logic [8:0] shifter;
		logic [3:0] bits_left;
		tx_state_t state;
		logic [7:0] div_cnt;
		logic [5:0] tick_cnt;
		logic pin;
		logic pin_oe;
		logic rx_oe;
		logic irq;
		logic ack;
		logic wreq;
		logic [31:0] rdata;
		logic rx_meta;
		logic rx_sync;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] wmask);
		merge = (old & ~wmask) | (avs_writedata_in[7:0] & wmask);
	endfunction

	logic run;
	logic baud_tick;
	logic bus_req;
	logic wr_hit;
	logic hold_wr;
	logic [7:0] tx_status;
	assign run = s_q.tx_ctrl[tx_enable_pos] & ~s_q.tx_ctrl[sync_sel_pos]
		& s_q.rx_ctrl[port_enable_pos]; // [R6]
	assign bus_req = (avs_read_in | avs_write_in) & ~s_q.ack;
	assign wr_hit = bus_req & avs_write_in & avs_byteenable_in[0];
	assign hold_wr = wr_hit & (avs_address_in == tx_holding_off);
	assign tx_status = {s_q.tx_ctrl[7:2], (s_q.state == st_idle),
		s_q.tx_ctrl[0]}; // [R17]

	always_comb begin
		baud_tick = 1'b0;
		if (s_q.div_cnt == 8'h00) begin
			if (s_q.tx_ctrl[high_speed_pos]) begin
				baud_tick = (s_q.tick_cnt == high_speed_ticks);
			end else begin
				baud_tick = (s_q.tick_cnt == low_speed_ticks);
			end
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rx_meta = receive_data_pin_in;
		s_d.rx_sync = s_q.rx_meta;
		// one wait state: answer at the cycle after the request
		s_d.ack = bus_req;
		s_d.wreq = ~bus_req;
		s_d.rdata = 32'h0000_0000;
		if (bus_req && avs_read_in) begin
			case (avs_address_in)
				tx_ctrl_status_off: s_d.rdata[7:0] = tx_status;
				rx_ctrl_status_off: s_d.rdata[7:0] = s_q.rx_ctrl;
				baud_divider_off: s_d.rdata[7:0] = s_q.divider;
				pending_flags_off: s_d.rdata[tx_flag_pos] = s_q.flag; // [R14]
				enable_mask_off: s_d.rdata[7:0] = s_q.mask;
				irq_control_off: s_d.rdata[7:0] = s_q.irq_ctrl;
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_hit) begin
			case (avs_address_in)
				tx_ctrl_status_off:
					s_d.tx_ctrl = merge(s_q.tx_ctrl, tx_ctrl_wmask);
				rx_ctrl_status_off: s_d.rx_ctrl = avs_writedata_in[7:0];
				baud_divider_off: s_d.divider = avs_writedata_in[7:0];
				enable_mask_off: s_d.mask = avs_writedata_in[7:0];
				irq_control_off: s_d.irq_ctrl = avs_writedata_in[7:0];
				tx_holding_off: begin
					// ninth bit captured with the low byte [R19]
					s_d.holding = avs_writedata_in[7:0];
					s_d.holding_ninth = s_q.tx_ctrl[ninth_bit_pos];
					s_d.holding_full = 1'b1;
					s_d.lag = flag_lag;
				end
				default: s_d.rdata = s_q.rdata;
			endcase
		end
		// baud generator, restarted with each frame [R4]
		if (s_q.state == st_idle) begin
			s_d.div_cnt = s_q.divider;
			s_d.tick_cnt = 6'h00;
		end else if (s_q.div_cnt != 8'h00) begin
			s_d.div_cnt = s_q.div_cnt - 8'h01;
		end else begin
			s_d.div_cnt = s_q.divider;
			s_d.tick_cnt = baud_tick ? 6'h00 : s_q.tick_cnt + 6'h01;
		end
		case (s_q.state)
			st_idle: begin
				s_d.pin = 1'b1; // [R1]
				if (run && s_q.holding_full) begin
					// empty shifter takes the character at once [R10] [R11]
					s_d.shifter = {s_q.holding_ninth, s_q.holding};
					s_d.bits_left = s_q.tx_ctrl[nine_bit_pos] ?
						bits_nine : bits_eight; // [R18] [R5]
					s_d.holding_full = hold_wr;
					s_d.state = st_start;
					s_d.pin = 1'b0; // [R2]
				end
			end
			st_start: if (baud_tick) begin
				s_d.pin = s_q.shifter[0]; // [R3]
				s_d.shifter = {1'b0, s_q.shifter[8:1]};
				s_d.bits_left = s_q.bits_left - 4'h1;
				s_d.state = st_data;
			end
			st_data: if (baud_tick) begin
				if (s_q.bits_left == 4'h0) begin
					s_d.pin = 1'b1; // [R2]
					s_d.state = st_stop;
				end else begin
					s_d.pin = s_q.shifter[0]; // [R3] [R20]
					s_d.shifter = {1'b0, s_q.shifter[8:1]};
					s_d.bits_left = s_q.bits_left - 4'h1;
				end
			end
			st_stop: if (baud_tick) begin
				s_d.state = st_idle;
			end
			default: s_d.state = st_idle;
		endcase
		if (!run) begin
			// disabled: abort frame, hold mark [R23]
			s_d.state = st_idle;
			s_d.pin = 1'b1;
		end
		// flag follows buffer, delayed after writes [R12] [R13] [R9]
		// a fresh buffer write restarts the lag rather than losing it
		if (hold_wr) begin
			s_d.lag = flag_lag;
		end else if (s_q.lag != 2'h0) begin
			s_d.lag = s_q.lag - 2'h1;
		end else begin
			s_d.flag = run & ~s_q.holding_full;
		end
		if (!run) begin
			s_d.flag = 1'b0;
		end
		s_d.irq = s_q.flag & s_q.mask[tx_flag_pos]
			& s_q.irq_ctrl[global_irq_pos]
			& s_q.irq_ctrl[periph_irq_pos]; // [R15] [R21]
		s_d.pin_oe = s_q.rx_ctrl[port_enable_pos]; // [R7]
		s_d.rx_oe = 1'b0; // [R8]
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_q <= '0;
			s_q.tx_ctrl <= tx_ctrl_reset;
			s_q.rx_ctrl <= zero_byte_reset;
			s_q.state <= st_idle;
			s_q.pin <= 1'b1;
			s_q.wreq <= 1'b1;
			s_q.rx_meta <= 1'b1;
			s_q.rx_sync <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata_out = s_q.rdata;
	assign avs_waitrequest_out = s_q.wreq;
	assign transmit_clock_pin_out = s_q.pin;
	assign transmit_clock_pin_oe_out = s_q.pin_oe;
	assign receive_data_pin_oe_out = s_q.rx_oe;
	assign irq_out = s_q.irq;
endmodule

// ### hdl/serial_tx_pkg.sv
// Purpose: constants for the asynchronous serial transmitter
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: registers hold 8 bits in the low byte, upper bits read zero
package serial_tx_pkg;
	// register byte offsets
	localparam logic [4:0] tx_ctrl_status_off = 5'h00;
	localparam logic [4:0] rx_ctrl_status_off = 5'h04;
	localparam logic [4:0] baud_divider_off = 5'h08;
	localparam logic [4:0] tx_holding_off = 5'h0c;
	localparam logic [4:0] pending_flags_off = 5'h10;
	localparam logic [4:0] enable_mask_off = 5'h14;
	localparam logic [4:0] irq_control_off = 5'h18;
	// transmit_control_status fields
	localparam int nine_bit_pos = 6;
	localparam int tx_enable_pos = 5;
	localparam int sync_sel_pos = 4;
	localparam int high_speed_pos = 2;
	localparam int shifter_empty_pos = 1;
	localparam int ninth_bit_pos = 0;
	// receive_control_status, pending, mask, irq control fields
	localparam int port_enable_pos = 7;
	localparam int tx_flag_pos = 4;
	localparam int global_irq_pos = 7;
	localparam int periph_irq_pos = 6;
	// reset values
	localparam logic [7:0] tx_ctrl_reset = 8'h02;
	localparam logic [7:0] zero_byte_reset = 8'h00;
	// writable bits of transmit_control_status
	localparam logic [7:0] tx_ctrl_wmask = 8'hf5;
	// baud period in clocks: high speed 16x, normal 64x per divider step
	localparam logic [5:0] high_speed_ticks = 6'h0f;
	localparam logic [5:0] low_speed_ticks = 6'h3f;
	// data bits per frame
	localparam logic [3:0] bits_eight = 4'h8;
	localparam logic [3:0] bits_nine = 4'h9;
	// buffer-empty flag lag after a buffer write, in clocks
	localparam logic [1:0] flag_lag = 2'h2;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_start = 2'b01,
		st_data = 2'b11,
		st_stop = 2'b10
	} tx_state_t;
endpackage

// ### verif/serial_rx_model.sv
// Purpose: remote receiver on the serial line
// Assumes: BIT clocks per bit, sampled mid-bit
// Notes: nine_in picks 8 or 9 data bits
`timescale 1ns/1ps
module serial_rx_model #(parameter int BIT = 16) (
	input wire logic clock_in,
	input wire logic line_in,
	input wire logic nine_in,
	output logic [8:0] data_out,
	output logic stop_ok_out,
	output int count_out
);
	logic [8:0] sr;
	logic st;
	initial begin
		count_out = 0;
		data_out = '0;
		stop_ok_out = 1'b0;
		forever begin
			@(negedge line_in);
			repeat (BIT / 2) @(posedge clock_in);
			st = line_in;
			sr = '0;
			for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
				repeat (BIT) @(posedge clock_in);
				sr[i] = line_in;
			end
			repeat (BIT) @(posedge clock_in);
			data_out <= sr;
			stop_ok_out <= line_in && !st;
			count_out <= count_out + 1;
		end
	end
endmodule

// ### verif/serial_tx_checker.sv
// Purpose: port-level checks for serial_tx
// Assumes: sees only the top ports
// Notes: a bit always spans a multiple of 16 clocks
`timescale 1ns/1ps
module serial_tx_checker
	import serial_tx_pkg::*;
(
	input logic clock_in,
	input logic sys_rst_in,
	input logic [4:0] avs_address_in,
	input logic avs_read_in,
	input logic avs_write_in,
	input logic [31:0] avs_writedata_in,
	input logic [3:0] avs_byteenable_in,
	input logic avs_waitrequest_out,
	input logic transmit_clock_pin_out,
	input logic transmit_clock_pin_oe_out,
	input logic receive_data_pin_oe_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	logic [3:0] low_q;
	always_ff @(posedge clock_in) begin
		low_q <= (sys_rst_in || transmit_clock_pin_out) ? 4'h0 : low_q + 4'h1;
	end
	sequence s_req;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_port_wr;
		avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] &&
			avs_address_in == rx_ctrl_status_off;
	endsequence
	a_wait_one: assert property (s_req |=> !avs_waitrequest_out)
		else $error("request not answered in one cycle");
	a_ack_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("answer held too long");
	a_ack_cause: assert property ($fell(avs_waitrequest_out) |->
		$past(avs_read_in || avs_write_in)) else $error("answer without request");
	a_rx_input: assert property (!receive_data_pin_oe_out)
		else $error("receive pin driven");
	a_port_oe: assert property (s_port_wr ##2 1 |->
		transmit_clock_pin_oe_out == $past(avs_writedata_in[7], 2))
		else $error("transmit pin enable does not follow port enable");
	a_bit_span: assert property ($rose(transmit_clock_pin_out) |-> low_q == 4'h0)
		else $error("low span not whole bits");
	a_mark_off: assert property (!transmit_clock_pin_oe_out &&
		$past(!transmit_clock_pin_oe_out) |-> transmit_clock_pin_out)
		else $error("line not at mark while port off");
	a_start_port: assert property ($fell(transmit_clock_pin_out) |->
		transmit_clock_pin_oe_out) else $error("frame with port off");
endmodule
bind serial_tx serial_tx_checker i_chk (.*);

// ### verif/serial_tx_test.sv
// Purpose: self-checking bench for serial_tx
// Assumes: divider 0 and high speed, one bit is 16 clocks
// Notes: the receiver model decodes the line
`timescale 1ns/1ps
module serial_tx_test;
	import serial_tx_pkg::*;
	logic clock_in = 0, sys_rst_in = 1, rd = 0, wr = 0, nine = 0;
	logic pin, oe, rx_oe, irq, wreq, stop_ok;
	logic [4:0] addr = 5'h00;
	logic [31:0] wd = 32'h0000_0000, rdata, q;
	logic [8:0] rx_data;
	int rx_cnt, bad_count = 0, n_compared = 0;
	always #20 clock_in = ~clock_in;
	serial_tx i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(4'hf),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.receive_data_pin_in(1'b1), .transmit_clock_pin_out(pin),
		.transmit_clock_pin_oe_out(oe), .receive_data_pin_oe_out(rx_oe),
		.irq_out(irq));
	serial_rx_model #(.BIT(16)) i_rx (.clock_in(clock_in), .line_in(pin),
		.nine_in(nine), .data_out(rx_data), .stop_ok_out(stop_ok),
		.count_out(rx_cnt));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, e);
		n_compared++;
		if (got !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, got);
		end
	endtask
	// trailing edges let the two-cycle flag lag settle
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		addr <= a;
		wd <= {24'h00_0000, d};
		wr <= w;
		rd <= !w;
		@(posedge clock_in);
		while (wreq !== 1'b0) @(posedge clock_in);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), q, e);
	endtask
	task automatic wait_rx(input int n);
		for (int k = 0; k < 400 && rx_cnt < n; k++) @(posedge clock_in);
		chk("frames", rx_cnt, n);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rchk(tx_ctrl_status_off, 32'h0000_0002);
		rchk(pending_flags_off, 32'h0000_0000);
		rchk(5'h1c, 32'h0000_0000);
		chk("pin", pin, 1'b1);
	endtask
	task automatic t_setup;
		bus(1'b1, baud_divider_off, 8'h00);
		bus(1'b1, rx_ctrl_status_off, 8'h80);
		chk("tx oe", oe, 1'b1);
		chk("rx oe", rx_oe, 1'b0);
		bus(1'b1, tx_ctrl_status_off, 8'h24);
		rchk(pending_flags_off, 32'h0000_0010);
		bus(1'b1, pending_flags_off, 8'h00);
		rchk(pending_flags_off, 32'h0000_0010);
		bus(1'b1, irq_control_off, 8'hc0);
		chk("irq off", irq, 1'b0);
		bus(1'b1, enable_mask_off, 8'h10);
		chk("irq on", irq, 1'b1);
		bus(1'b1, enable_mask_off, 8'h00);
	endtask
	task automatic t_send8;
		bus(1'b1, tx_holding_off, 8'ha5);
		bus(1'b1, tx_holding_off, 8'h3c);
		rchk(pending_flags_off, 32'h0000_0000);
		rchk(tx_ctrl_status_off, 32'h0000_0024);
		wait_rx(1);
		chk("byte 1", rx_data, 9'h0a5);
		repeat (12) @(posedge clock_in);
		rchk(pending_flags_off, 32'h0000_0010);
		wait_rx(2);
		chk("byte 2", rx_data, 9'h03c);
		chk("stop", stop_ok, 1'b1);
		repeat (12) @(posedge clock_in);
		rchk(tx_ctrl_status_off, 32'h0000_0026);
	endtask
	task automatic t_send9;
		nine = 1'b1;
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, tx_ctrl_status_off, 8'h65 - 8'(i));
			bus(1'b1, tx_holding_off, 8'h5a + 8'(i));
			wait_rx(3 + i);
			chk("nine", rx_data, {!i[0], 8'h5a + 8'(i)});
		end
		nine = 1'b0;
		repeat (12) @(posedge clock_in);
	endtask
	task automatic t_off;
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, tx_ctrl_status_off, i ? 8'h04 : 8'h34);
			bus(1'b1, tx_holding_off, 8'h00);
			repeat (200) @(posedge clock_in);
			chk("idle", {pin, 31'(rx_cnt)}, 32'h8000_0004);
		end
		rchk(pending_flags_off, 32'h0000_0000);
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		t_regs();
		t_setup();
		t_send8();
		t_send9();
		t_off();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clock_in);
		bad_count++;
		report_and_stop();
	end
endmodule
